// ===== rtl/rps_debounce.sv
// Level debouncer: output follows input after it holds for a selected count
`timescale 1ns/10ps
`default_nettype none
module rps_debounce #(
  parameter int unsigned SHORT_CYC = 200000,
  parameter int unsigned LONG_CYC = 1600000
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Control
  input wire logic i_long,
  input wire logic i_bypass,
  input wire logic i_level,
  // Result
  output logic o_level
);

  localparam int unsigned CW = $clog2(LONG_CYC + 1);

  logic [CW-1:0] cnt_q;
  logic level_q;
  logic [CW-1:0] limit;

  assign limit = i_long ? CW'(LONG_CYC - 1) : CW'(SHORT_CYC - 1);

  // Counter restarts whenever the input matches the held level
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn || i_bypass || i_level == level_q)
    begin
      cnt_q <= '0;
    end
    else if (cnt_q < limit)
    begin
      cnt_q <= cnt_q + CW'(1);
    end
    else
    begin
      cnt_q <= '0;
    end
  end

  // Held level changes after full stable time, or at once when bypassed
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      level_q <= 1'b0;
    end
    else if (i_bypass || (i_level != level_q && cnt_q >= limit))
    begin
      level_q <= i_level;
    end
  end

  assign o_level = level_q;

endmodule
`default_nettype wire

// ===== rtl/rps_pkg.sv
// Package for the reset and low-power mode sequencer: constants and types
package rps_pkg;

  // Clock and timing
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned OSC_HZ = 32768;
  localparam int unsigned POR_OSC_CYCLES = 32768;
  localparam int unsigned DEB_SHORT_MS = 2;
  localparam int unsigned DEB_LONG_MS = 16;
  localparam int unsigned PIN_MIN_NS = 2000;
  // Least times round up, at least one cycle
  localparam int unsigned PIN_MIN_CYC = (PIN_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned DEB_SHORT_CYC = DEB_SHORT_MS * (CLK_HZ / 1000);
  localparam int unsigned DEB_LONG_CYC = DEB_LONG_MS * (CLK_HZ / 1000);
  // Half period of the oscillator in system clocks, rounded down
  localparam int unsigned OSC_HALF_CYC = CLK_HZ / (2 * OSC_HZ);

  // Register map
  localparam logic [3:0] ADDR_MODE = 4'h0;
  localparam logic [3:0] ADDR_IRQ = 4'h1;
  localparam logic [3:0] ADDR_CTRL = 4'h2;
  localparam logic [3:0] ADDR_STATUS = 4'h3;
  localparam logic [3:0] ADDR_CPU = 4'h4;

  // Field positions
  localparam int unsigned BIT_SLEEP = 0;
  localparam int unsigned BIT_GUARD = 1;
  localparam int unsigned BIT_DEBSEL = 0;
  localparam int unsigned BIT_WDDIS = 1;
  localparam int unsigned BIT_CLKOUT = 2;
  localparam int unsigned BIT_HALT = 0;

  // Reset values
  localparam logic [11:0] PC0_RESET = 12'h000;
  localparam logic [15:0] JUMP_ZERO = 16'h0000;
  localparam logic [1:0] SP_RESET = 2'h0;

  // Port A reset combinations
  typedef enum logic [1:0] {
    RPS_COMB_NONE = 2'h0,
    RPS_COMB_01 = 2'h1,
    RPS_COMB_012 = 2'h2,
    RPS_COMB_0123 = 2'h3
  } rps_comb_t;

  // Mode states, Gray along active-standby-sleep-reset
  typedef enum logic [1:0] {
    RPS_ST_ACTIVE = 2'b00,
    RPS_ST_STANDBY = 2'b01,
    RPS_ST_SLEEP = 2'b11,
    RPS_ST_RESET = 2'b10
  } rps_state_t;

  // Reset cause vector
  typedef struct packed {
    logic por;
    logic pin;
    logic comb;
    logic wdog;
    logic osc;
  } rps_cause_t;

  // CPU state loaded at reset
  typedef struct packed {
    logic [15:0] instr;
    logic [11:0] pc0;
    logic [1:0] sp;
    logic halt;
  } rps_cpu_t;

endpackage

// ===== rtl/rps_sequencer.sv
// Reset and low-power mode sequencer: modes, reset sources, CPU reset state
//
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module rps_sequencer #(
  parameter rps_pkg::rps_comb_t COMB_SEL = rps_pkg::RPS_COMB_NONE,
  parameter int unsigned POR_CYC = rps_pkg::POR_OSC_CYCLES,
  parameter int unsigned OSC_HALF = rps_pkg::OSC_HALF_CYC,
  parameter int unsigned DEB_SHORT = rps_pkg::DEB_SHORT_CYC,
  parameter int unsigned DEB_LONG = rps_pkg::DEB_LONG_CYC
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Register port
  input wire logic [3:0] i_addr,
  input wire logic [3:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [3:0] o_rdata,
  // Reset sources and events
  input wire logic i_reset_pin,
  input wire logic [3:0] i_in_a,
  input wire logic i_wdog_timeout,
  input wire logic i_osc_alive,
  input wire logic i_halt_instr,
  input wire logic i_irq_enabled,
  // Outputs to the core and pins
  output logic o_strobe_reset_out,
  output logic o_sys_reset,
  output logic o_cpu_clk_en,
  output logic o_osc_en,
  output logic o_periph_run,
  output logic o_regs_clear,
  output rps_pkg::rps_cpu_t o_cpu_init,
  output rps_pkg::rps_cause_t o_cause
);

  localparam int unsigned PCW = $clog2(POR_CYC + 1);
  localparam int unsigned OCW = $clog2(OSC_HALF + 1);
  localparam int unsigned PMW = $clog2(rps_pkg::PIN_MIN_CYC + 1);

  // Port A combination mask, fixed at build
  function automatic logic [3:0] comb_mask(input rps_pkg::rps_comb_t sel);
    unique case (sel)
      rps_pkg::RPS_COMB_NONE: comb_mask = 4'h0;
      rps_pkg::RPS_COMB_01: comb_mask = 4'h3;
      rps_pkg::RPS_COMB_012: comb_mask = 4'h7;
      rps_pkg::RPS_COMB_0123: comb_mask = 4'hf;
    endcase
  endfunction
  localparam logic [3:0] COMB_MASK = comb_mask(COMB_SEL);

  rps_pkg::rps_state_t state_q;
  logic [1:0] pin_sync_q;
  logic [1:0] a0_sync_q, a1_sync_q, a2_sync_q, a3_sync_q;
  logic [1:0] wd_sync_q;
  logic [1:0] osc_sync_q;
  logic pin_s, wd_s, osc_s;
  logic [3:0] a_s;
  logic pin_deb, comb_raw, comb_deb;
  logic [PCW-1:0] por_cnt_q;
  logic [OCW-1:0] osc_div_q;
  logic osc_tick_q, fout_q;
  logic por_busy_q;
  logic powered_q;
  logic [PMW-1:0] pin_hold_q;
  logic sleep_q, guard_q;
  logic debsel_q, wddis_q, clkout_q;
  logic halt_q;
  logic pin_bypass;
  logic pin_wake;
  logic rst_req;
  logic rst_q;
  rps_pkg::rps_cause_t cause_q;
  logic [3:0] rdata_q;

  // Two-flop synchronisers; only stage two is used downstream
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      pin_sync_q <= 2'h0;
      wd_sync_q <= 2'h0;
      osc_sync_q <= 2'h0;
      a0_sync_q <= 2'h0;
      a1_sync_q <= 2'h0;
      a2_sync_q <= 2'h0;
      a3_sync_q <= 2'h0;
    end
    else
    begin
      pin_sync_q <= {pin_sync_q[0], i_reset_pin};
      wd_sync_q <= {wd_sync_q[0], i_wdog_timeout};
      osc_sync_q <= {osc_sync_q[0], i_osc_alive};
      a0_sync_q <= {a0_sync_q[0], i_in_a[0]};
      a1_sync_q <= {a1_sync_q[0], i_in_a[1]};
      a2_sync_q <= {a2_sync_q[0], i_in_a[2]};
      a3_sync_q <= {a3_sync_q[0], i_in_a[3]};
    end
  end

  assign pin_s = pin_sync_q[1];
  assign wd_s = wd_sync_q[1];
  assign osc_s = osc_sync_q[1];
  assign a_s = {a3_sync_q[1], a2_sync_q[1], a1_sync_q[1], a0_sync_q[1]};
  // Port A combination: all selected inputs high, never during sleep
  assign comb_raw = (COMB_MASK != 4'h0) && ((a_s & COMB_MASK) == COMB_MASK)
    && (state_q != rps_pkg::RPS_ST_SLEEP);
  // Pin debouncer bypassed at power-on and while asleep; the combination debouncer is never bypassed
  assign pin_bypass = por_busy_q || (state_q == rps_pkg::RPS_ST_SLEEP);
  rps_debounce #(
    .SHORT_CYC(DEB_SHORT),
    .LONG_CYC(DEB_LONG)
  ) u_pin_deb (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_long(debsel_q),
    .i_bypass(pin_bypass),
    .i_level(pin_s),
    .o_level(pin_deb)
  );
  rps_debounce #(
    .SHORT_CYC(DEB_SHORT),
    .LONG_CYC(DEB_LONG)
  ) u_comb_deb (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_long(debsel_q),
    .i_bypass(1'b0),
    .i_level(comb_raw),
    .o_level(comb_deb)
  );

  // Pin held high long enough in sleep: analog filter model
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn || !pin_s || state_q != rps_pkg::RPS_ST_SLEEP)
    begin
      pin_hold_q <= '0;
    end
    else if (pin_hold_q != PMW'(rps_pkg::PIN_MIN_CYC))
    begin
      pin_hold_q <= pin_hold_q + PMW'(1);
    end
  end
  assign pin_wake = (pin_hold_q == PMW'(rps_pkg::PIN_MIN_CYC));
  // Oscillator tick generator; held cleared in sleep
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn || state_q == rps_pkg::RPS_ST_SLEEP)
    begin
      osc_div_q <= '0;
      osc_tick_q <= 1'b0;
      fout_q <= 1'b0;
    end
    else if (osc_div_q == OCW'(OSC_HALF - 1))
    begin
      osc_div_q <= '0;
      osc_tick_q <= fout_q; // One tick per full period
      fout_q <= ~fout_q;
    end
    else
    begin
      osc_div_q <= osc_div_q + OCW'(1);
      osc_tick_q <= 1'b0;
    end
  end

  // Start-up count: restarts on power-on and on sleep wake
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn || (state_q == rps_pkg::RPS_ST_SLEEP && pin_wake))
    begin
      por_cnt_q <= '0;
      por_busy_q <= 1'b1;
    end
    else if (por_busy_q && osc_tick_q)
    begin
      if (por_cnt_q == PCW'(POR_CYC - 1))
      begin
        por_busy_q <= 1'b0;
      end
      por_cnt_q <= por_cnt_q + PCW'(1);
    end
  end

  // Power-up complete marker arms the oscillator monitor
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      powered_q <= 1'b0;
    end
    else if (!por_busy_q)
    begin
      powered_q <= 1'b1;
    end
  end

  // Reset request from all sources
  always_comb
  begin
    cause_q = '0;
    cause_q.por = por_busy_q;
    cause_q.pin = pin_deb && (state_q != rps_pkg::RPS_ST_SLEEP);
    cause_q.comb = comb_deb;
    cause_q.wdog = wd_s && !wddis_q && (state_q != rps_pkg::RPS_ST_SLEEP);
    cause_q.osc = powered_q && !osc_s && (state_q != rps_pkg::RPS_ST_SLEEP);
    rst_req = |cause_q;
  end

  // Registered reset, clean edge-aligned release
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      rst_q <= 1'b1;
    end
    else
    begin
      // Wake edge itself held in reset, else strobe drops for a cycle
      rst_q <= rst_req || (state_q == rps_pkg::RPS_ST_SLEEP && pin_wake);
    end
  end

  // Mode state machine
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      state_q <= rps_pkg::RPS_ST_RESET;
    end
    else
    begin
      unique case (state_q)
        rps_pkg::RPS_ST_ACTIVE:
        begin
          if (rst_req)
            state_q <= rps_pkg::RPS_ST_RESET;
          else if (sleep_q)
            state_q <= rps_pkg::RPS_ST_SLEEP;
          else if (i_halt_instr)
            state_q <= rps_pkg::RPS_ST_STANDBY;
        end
        rps_pkg::RPS_ST_STANDBY:
        begin
          if (rst_req)
            state_q <= rps_pkg::RPS_ST_RESET;
          else if (i_irq_enabled)
            state_q <= rps_pkg::RPS_ST_ACTIVE;
        end
        rps_pkg::RPS_ST_SLEEP:
        begin
          if (pin_wake)
            state_q <= rps_pkg::RPS_ST_RESET;
        end
        rps_pkg::RPS_ST_RESET:
        begin
          if (!rst_req)
            state_q <= rps_pkg::RPS_ST_ACTIVE;
        end
      endcase
    end
  end

  // Sleep flag and write guard; guard survives sleep wake
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      sleep_q <= 1'b0;
      guard_q <= 1'b0;
    end
    else
    begin
      if (state_q == rps_pkg::RPS_ST_SLEEP && pin_wake)
        sleep_q <= 1'b0;
      else if (i_wr && i_addr == rps_pkg::ADDR_MODE && guard_q
               && state_q == rps_pkg::RPS_ST_ACTIVE)
        sleep_q <= i_wdata[rps_pkg::BIT_SLEEP];
      if (i_wr && i_addr == rps_pkg::ADDR_MODE)
        guard_q <= i_wdata[rps_pkg::BIT_GUARD];
    end
  end

  // Control bits; cleared by sleep and by any system reset
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn || rst_q || state_q == rps_pkg::RPS_ST_SLEEP)
    begin
      debsel_q <= 1'b0;
      wddis_q <= 1'b0;
      clkout_q <= 1'b0;
    end
    else if (i_wr && i_addr == rps_pkg::ADDR_CTRL)
    begin
      debsel_q <= i_wdata[rps_pkg::BIT_DEBSEL];
      wddis_q <= i_wdata[rps_pkg::BIT_WDDIS];
      clkout_q <= i_wdata[rps_pkg::BIT_CLKOUT];
    end
  end

  // Halt flag cleared by reset
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn || rst_q)
      halt_q <= 1'b0;
    else
      halt_q <= (state_q == rps_pkg::RPS_ST_STANDBY);
  end

  // Read data, one cycle after the strobe; unmapped reads zero
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
      rdata_q <= 4'h0;
    else if (i_rd)
    begin
      unique case (i_addr)
        rps_pkg::ADDR_MODE: rdata_q <= {2'h0, guard_q, sleep_q};
        rps_pkg::ADDR_IRQ: rdata_q <= {3'h0, sleep_q};
        rps_pkg::ADDR_CTRL: rdata_q <= {1'b0, clkout_q, wddis_q, debsel_q};
        rps_pkg::ADDR_STATUS: rdata_q <= {2'h0, state_q};
        rps_pkg::ADDR_CPU: rdata_q <= {3'h0, halt_q};
        default: rdata_q <= 4'h0;
      endcase
    end
    else
      rdata_q <= 4'h0;
  end
  assign o_rdata = rdata_q;
  assign o_cause = cause_q;
  assign o_sys_reset = rst_q || state_q == rps_pkg::RPS_ST_SLEEP;
  // Strobe high in reset, or oscillator clock when enabled
  assign o_strobe_reset_out = rst_q || (clkout_q && fout_q);
  assign o_cpu_clk_en = (state_q == rps_pkg::RPS_ST_ACTIVE) && !rst_q;
  assign o_osc_en = (state_q != rps_pkg::RPS_ST_SLEEP);
  // Timer, watchdog, interrupts run in active and standby only
  assign o_periph_run = (state_q == rps_pkg::RPS_ST_ACTIVE)
    || (state_q == rps_pkg::RPS_ST_STANDBY);
  assign o_regs_clear = (state_q == rps_pkg::RPS_ST_SLEEP) || rst_q;
  assign o_cpu_init.instr = rps_pkg::JUMP_ZERO;
  assign o_cpu_init.pc0 = rps_pkg::PC0_RESET;
  assign o_cpu_init.sp = rps_pkg::SP_RESET;
  assign o_cpu_init.halt = halt_q;

endmodule
`default_nettype wire

// ===== verif/rps_core_model.sv
// Behavioural model of crystal, reset pin and halting core
`timescale 1ns/10ps
`default_nettype none
module rps_core_model (
  // Clock
  input wire logic i_clk,
  // From the sequencer
  input wire logic i_osc_en,
  // To the sequencer
  output logic o_osc_alive,
  output logic o_reset_pin,
  output logic o_halt_instr
);
  logic [1:0] start_q;
  logic kill_q;

  // Crystal takes two cycles to start, stops one cycle after it is disabled
  always_ff @(posedge i_clk)
    start_q <= (i_osc_en && !kill_q) ? {start_q[0], 1'b1} : 2'h0;
  assign o_osc_alive = start_q[1];

  // Pin has a pull-down, so released it reads low
  initial
  begin
    o_reset_pin = 1'b0;
    o_halt_instr = 1'b0;
    kill_q = 1'b0;
  end

  // Pin high for n cycles
  task automatic pin_pulse(input int n);
    @(posedge i_clk) o_reset_pin <= 1'b1;
    repeat (n) @(posedge i_clk);
    o_reset_pin <= 1'b0;
  endtask

  // One-cycle halt instruction
  task automatic halt();
    @(posedge i_clk) o_halt_instr <= 1'b1;
    @(posedge i_clk) o_halt_instr <= 1'b0;
  endtask

  // Crystal failure outside sleep
  task automatic stop_osc(input logic v);
    @(posedge i_clk) kill_q <= v;
  endtask
endmodule
`default_nettype wire

// ===== verif/rps_sequencer_properties.sv
// Port assertions for the reset and low-power mode sequencer
`timescale 1ns/10ps
`default_nettype none
module rps_sequencer_properties #(
  parameter int unsigned POR_CYC = 4,
  parameter int unsigned OSC_HALF = 2
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Watched inputs
  input wire logic i_rd,
  input wire logic i_reset_pin,
  input wire logic i_osc_alive,
  input wire logic i_halt_instr,
  input wire logic i_irq_enabled,
  // Watched outputs
  input wire logic [3:0] o_rdata,
  input wire logic o_strobe_reset_out,
  input wire logic o_sys_reset,
  input wire logic o_cpu_clk_en,
  input wire logic o_osc_en,
  input wire logic o_periph_run,
  input wire logic o_regs_clear,
  input wire rps_pkg::rps_cpu_t o_cpu_init,
  input wire rps_pkg::rps_cause_t o_cause
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  logic por_q;
  int unsigned run_q;

  // Age since release, only meaningful until the first hold ends
  always_ff @(posedge i_clk)
    if (!i_resetn)
    begin
      por_q <= 1'b1;
      run_q <= 0;
    end
    else
    begin
      run_q <= run_q + 1;
      por_q <= por_q && o_sys_reset;
    end

  chk_por_hold: assert property (
    por_q && $fell(o_sys_reset) |-> run_q >= (POR_CYC - 1) * 2 * OSC_HALF
  ) else $error("power-on hold too short");
  // One cycle of grace while the clock-out bit is being cleared
  chk_reset_strobe: assert property (
    o_sys_reset && $past(o_sys_reset) && o_osc_en |-> o_strobe_reset_out
  ) else $error("strobe low during reset");
  chk_cpu_init: assert property (
    o_sys_reset && $past(o_sys_reset) |-> o_cpu_init == '0
  ) else $error("cpu start state wrong");
  chk_halt_standby: assert property (
    i_halt_instr && o_cpu_clk_en && !i_irq_enabled && !o_sys_reset && !i_reset_pin
    |=> !o_cpu_clk_en && o_periph_run && o_osc_en
  ) else $error("halt did not enter standby");
  chk_standby_exit: assert property (
    !o_cpu_clk_en && o_periph_run && i_irq_enabled && !o_sys_reset |-> ##[1:2] o_cpu_clk_en
  ) else $error("interrupt did not end standby");
  chk_sleep_state: assert property (
    !o_osc_en |-> o_sys_reset && o_regs_clear && !o_periph_run && !o_cpu_clk_en
  ) else $error("sleep outputs wrong");
  chk_sleep_stay: assert property (
    !o_osc_en && !i_reset_pin && !$past(i_reset_pin) && !$past(i_reset_pin, 2)
    && !$past(i_reset_pin, 3) |=> !o_osc_en
  ) else $error("sleep left without pin");
  chk_wake_reset: assert property (
    $rose(o_osc_en) |-> o_sys_reset && o_strobe_reset_out
  ) else $error("wake without reset");
  chk_comb_sleep: assert property (
    !o_osc_en |-> !o_cause.comb
  ) else $error("input reset in sleep");
  chk_osc_stop: assert property (
    !i_osc_alive && o_osc_en && !o_sys_reset |-> ##[0:4] o_sys_reset
  ) else $error("oscillator stop missed");
  chk_read_idle: assert property (
    !$past(i_rd) |-> o_rdata == 4'h0
  ) else $error("read data outside slot");
endmodule
// Checker defaults match the bench's shortened start-up counts
bind rps_sequencer rps_sequencer_properties i_rps_sequencer_properties (.i_clk, .i_resetn,
  .i_rd, .i_reset_pin, .i_osc_alive,
  .i_halt_instr, .i_irq_enabled, .o_rdata, .o_strobe_reset_out, .o_sys_reset,
  .o_cpu_clk_en, .o_osc_en, .o_periph_run, .o_regs_clear, .o_cpu_init, .o_cause);
`default_nettype wire

// ===== verif/test_rps_sequencer.sv
// Self-checking testbench for the reset and low-power mode sequencer
`timescale 1ns/10ps
`default_nettype none
module test_rps_sequencer;
  logic i_clk, i_resetn, i_wr, i_rd, i_wdog_timeout, i_irq_enabled;
  logic [3:0] i_addr, i_wdata, i_in_a, o_rdata;
  logic i_reset_pin, i_osc_alive, i_halt_instr, o_strobe_reset_out;
  logic o_sys_reset, o_cpu_clk_en, o_osc_en, o_periph_run, o_regs_clear;
  rps_pkg::rps_cpu_t o_cpu_init;
  rps_pkg::rps_cause_t o_cause;
  int bad_count = 0;
  int cmp_count = 0;
  int n;
  logic [11:0] w;
  int plen[6] = '{2, 14, 6, 20, 20, 20};
  logic [3:0] pa[6] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'hd, 4'h3};

  // Short counts keep the run brief
  rps_sequencer #(.COMB_SEL(rps_pkg::RPS_COMB_01), .POR_CYC(4), .OSC_HALF(2),
    .DEB_SHORT(4), .DEB_LONG(8)) i_rps_sequencer (.i_clk, .i_resetn, .i_addr,
    .i_wdata, .i_wr, .i_rd, .o_rdata, .i_reset_pin, .i_in_a, .i_wdog_timeout,
    .i_osc_alive, .i_halt_instr, .i_irq_enabled, .o_strobe_reset_out, .o_sys_reset,
    .o_cpu_clk_en, .o_osc_en, .o_periph_run, .o_regs_clear, .o_cpu_init, .o_cause);
  rps_core_model i_rps_core_model (.i_clk, .i_osc_en(o_osc_en),
    .o_osc_alive(i_osc_alive), .o_reset_pin(i_reset_pin), .o_halt_instr(i_halt_instr));

  // 100 MHz clock
  initial
  begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // Whole run is under a thousand cycles
  initial
  begin
    repeat (20000) @(posedge i_clk);
    bad_count++;
    finish_test();
  end

  task automatic finish_test();
    if (bad_count == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Bus strobes go out on a rising edge; results are looked at on the falling one
  task automatic wr(input logic [3:0] a, input logic [3:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk) i_wr <= 1'b0;
    @(negedge i_clk);
  endtask

  task automatic rdc(input string what, input logic [3:0] a, input logic [3:0] exp);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk) i_rd <= 1'b0;
    @(negedge i_clk);
    check(what, o_rdata, exp);
  endtask

  task automatic wait_rst(input logic v, input int lim);
    n = 0;
    while (o_sys_reset !== v && n < lim)
    begin
      @(negedge i_clk);
      n++;
    end
  endtask

  initial
  begin
    i_resetn = 1'b0;
    i_addr = 4'h0;
    i_wdata = 4'h0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_in_a = 4'h0;
    i_wdog_timeout = 1'b0;
    i_irq_enabled = 1'b0;
    repeat (2) @(posedge i_clk);
    i_resetn <= 1'b1;
    @(negedge i_clk);
    check("strobe", o_strobe_reset_out, 1'b1);
    wait_rst(1'b0, 200);
    check("por hold", n >= 12, 1'b1);
    rdc("guard", rps_pkg::ADDR_MODE, 4'h0);
    rdc("state", rps_pkg::ADDR_STATUS, 4'h0);
    rdc("unmapped", 4'hf, 4'h0);
    // Clock-out must toggle the strobe pin
    wr(rps_pkg::ADDR_CTRL, 4'h4);
    repeat (12)
    begin
      @(negedge i_clk);
      w = {w[10:0], o_strobe_reset_out};
    end
    check("clock out", w != 12'h0 && w != 12'hfff, 1'b1);
    // Standby with watchdog reset disabled
    wr(rps_pkg::ADDR_CTRL, 4'h2);
    i_rps_core_model.halt();
    @(negedge i_clk);
    check("standby", {o_cpu_clk_en, o_periph_run, o_osc_en}, 3'h3);
    rdc("standby state", rps_pkg::ADDR_STATUS, 4'h1);
    rdc("ctrl kept", rps_pkg::ADDR_CTRL, 4'h2);
    rdc("halt flag", rps_pkg::ADDR_CPU, 4'h1);
    @(posedge i_clk) i_wdog_timeout <= 1'b1;
    wait_rst(1'b1, 20);
    check("wd off", o_sys_reset, 1'b0);
    @(posedge i_clk) i_irq_enabled <= 1'b1;
    @(posedge i_clk) i_irq_enabled <= 1'b0;
    rdc("irq wake", rps_pkg::ADDR_STATUS, 4'h0);
    // Long select set so the later read shows the reset clearing it
    wr(rps_pkg::ADDR_CTRL, 4'h1);
    wait_rst(1'b1, 10);
    check("wd reset", {o_sys_reset, o_cause.wdog}, 2'h3);
    @(posedge i_clk) i_wdog_timeout <= 1'b0;
    wait_rst(1'b0, 300);
    rdc("ctrl cleared", rps_pkg::ADDR_CTRL, 4'h0);
    // Pin with short and long debounce, then input combinations
    for (int k = 0; k < 6; k++)
    begin
      wr(rps_pkg::ADDR_CTRL, {3'h0, k[1]});
      if (k < 4)
        i_rps_core_model.pin_pulse(plen[k]);
      else
      begin
        @(posedge i_clk) i_in_a <= pa[k];
        repeat (plen[k]) @(posedge i_clk);
        i_in_a <= 4'h0;
      end
      wait_rst(1'b1, 30);
      check("reset source", o_sys_reset, k[0]);
      wait_rst(1'b0, 300);
    end
    // Sleep needs the guard first
    // Sleep flag lands on the write edge, the mode one edge later
    wr(rps_pkg::ADDR_MODE, 4'h1);
    @(negedge i_clk);
    check("unguarded", o_osc_en, 1'b1);
    wr(rps_pkg::ADDR_MODE, 4'h2);
    wr(rps_pkg::ADDR_MODE, 4'h3);
    @(negedge i_clk);
    check("sleep", {o_osc_en, o_sys_reset, o_regs_clear, o_periph_run}, 4'h6);
    @(posedge i_clk) i_in_a <= 4'hf;
    repeat (30) @(posedge i_clk);
    i_in_a <= 4'h0;
    i_rps_core_model.pin_pulse(100);
    @(negedge i_clk);
    check("sleep held", o_osc_en, 1'b0);
    i_rps_core_model.pin_pulse(rps_pkg::PIN_MIN_CYC + 8);
    @(negedge i_clk);
    check("wake", {o_osc_en, o_sys_reset, o_strobe_reset_out}, 3'h7);
    wait_rst(1'b0, 300);
    rdc("guard kept", rps_pkg::ADDR_MODE, 4'h2);
    rdc("sleep flag", rps_pkg::ADDR_IRQ, 4'h0);
    // Crystal failure while active
    i_rps_core_model.stop_osc(1'b1);
    wait_rst(1'b1, 20);
    check("osc stop", {o_sys_reset, o_cause.osc}, 2'h3);
    i_rps_core_model.stop_osc(1'b0);
    wait_rst(1'b0, 300);
    check("osc back", o_sys_reset, 1'b0);
    finish_test();
  end
endmodule
`default_nettype wire
